// File: include/ebi_pkg.sv
`default_nettype none
package ebi_pkg;
    // ------------------------------------------------------------
    // address map
    // ------------------------------------------------------------
    localparam logic [15:0] INT_LIMIT_NORMAL = 16'h1100;
    localparam logic [15:0] INT_LIMIT_LEGACY = 16'h1000;

    // ------------------------------------------------------------
    // control field layout and reset values
    // ------------------------------------------------------------
    localparam int WAIT_MSB_POS = 1;
    localparam int WAIT_LSB_POS = 0;
    localparam logic [1:0] WAIT_NONE = 2'h0;
    localparam logic [1:0] WAIT_ONE = 2'h1;
    localparam logic [2:0] SECTOR_RST = 3'h0;
    localparam logic [2:0] MASK_RST = 3'h0;
    localparam logic KEEPER_RST = 1'b0;
    localparam logic ENABLE_RST = 1'b0;

    // ------------------------------------------------------------
    // timing: the access is T1 (address, latch high), T2 (address held, latch low),
    // T3..T3+n (data out / strobe), n = wait setting; trailing latch pulse after
    // ------------------------------------------------------------
    localparam logic [1:0] STROBE_BASE = 2'h0;

    typedef struct packed {
        logic enable;
        logic legacy;
        logic keeper_en;
        logic [2:0] sector_limit;
        logic [1:0] upper_sector_wait;
        logic [1:0] lower_sector_wait;
        logic [2:0] high_addr_release_mask;
    } ebi_ctrl_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic next_is_ram;
    } ebi_req_type;

    typedef struct packed {
        logic [7:0] ad_out;
        logic [7:0] ad_oe_n;
        logic [7:0] ad_pullup;
        logic [7:0] hi_out;
        logic [7:0] hi_oe_n;
        logic ale;
        logic rd_n;
        logic wr_n;
        logic strobe_oe_n;
    } ebi_pins_type;
endpackage
`default_nettype wire

// File: hw/ebi_addr_decode.sv
`timescale 1ns/1ps
`default_nettype none
module ebi_addr_decode
(
    input wire logic [15:0] addr,
    input wire logic enable,
    input wire logic legacy,
    input wire logic [2:0] sector_limit,
    input wire logic [1:0] upper_sector_wait,
    input wire logic [1:0] lower_sector_wait,
    output logic is_external,
    output logic [1:0] wait_sel
);
    logic [15:0] limit;
    logic upper;

    always_comb
    begin
        // R16 R18
        limit = legacy ? ebi_pkg::INT_LIMIT_LEGACY : ebi_pkg::INT_LIMIT_NORMAL;
        // R08: with the interface off nothing above the boundary is external or aliased
        is_external = enable && (addr >= limit); // R03
        // R14: sector limit 0 means a single sector using the upper setting
        upper = (sector_limit == 3'h0) || (addr[15:13] >= sector_limit);
        // R15 R22
        if (legacy)
            wait_sel = {1'b0, upper_sector_wait[ebi_pkg::WAIT_LSB_POS]};
        else
            wait_sel = upper ? upper_sector_wait : lower_sector_wait;
    end
endmodule
`default_nettype wire

// File: hw/ebi_bus_keeper.sv
`timescale 1ns/1ps
`default_nettype none
module ebi_bus_keeper
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic keep_en,
    input wire logic released,
    input wire logic [7:0] pad_in,
    output logic [7:0] keep_out,
    output logic [7:0] keep_oe_n
);
    logic [7:0] level_r;

    // ------------------------------------------------------------
    // last-level capture
    // ------------------------------------------------------------
    // the pad is sampled only while something else drives it, so the
    // keeper never latches its own weak value back as new data
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            level_r <= 8'h00;
        else if (!released)
            level_r <= pad_in; // R11
    end

    assign keep_out = level_r;
    assign keep_oe_n = (keep_en && released) ? 8'h00 : 8'hff; // R11
endmodule
`default_nettype wire

// File: hw/ebi_core.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// R01 - multiplexed low address/data bus, separate high address bus, latch and strobes
// R02 - enabled interface overrides direction settings of its dedicated pins
// R03 - each access decoded internal/external; external ones drive pins
// R04 - low address valid on shared bus when latch strobe falls
// R05 - latch strobe stays low throughout data transfer phase
// R06 - internal accesses show bus activity but never pulse read or write
// R07 - disabled interface returns pins to port values and directions
// R08 - disabled interface never aliases high addresses onto internal memory
// R09 - shared bus pull-up follows port output register bit being one
// R10 - software should clear port bits before sleep to save power
// R11 - bus-keeper holds last shared bus level when lines released
// R12 - four wait settings, two bits per sector, including zero wait
// R13 - trailing latch pulse in T4..T7 only when next instruction uses RAM
// R14 - external space may split into two sectors with own settings
// R15 - upper sector uses upper wait pair, lower sector lower pair
// R16 - lowest 4352 addresses internal; external addresses output unchanged
// R17 - 32K memory systems use aliased range, avoid higher addresses
// R18 - legacy mode: only lowest 4096 addresses internal
// R19 - external parts must treat interface as asynchronous
// R20 - external latch transparent while strobe high, holds after fall
// R21 - control bits come from three software-written control registers
// R22 - legacy: waits 00/01 only, fixed high bits, no sectors or keeper
// R23 - software may release top high address bits to port function
// R24 - read/write strobes active low, exclusive, lengthened by wait setting
// R25 - reset leaves interface disabled, zero wait, no split, keeper off
module ebi_core
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic ctrl_wr,
    input wire ebi_pkg::ebi_ctrl_type ctrl_in,
    input wire ebi_pkg::ebi_req_type req,
    output logic req_ready,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic access_external,
    input wire logic [7:0] port_ad_val,
    input wire logic [7:0] port_ad_dir,
    input wire logic [7:0] port_hi_val,
    input wire logic [7:0] port_hi_dir,
    input wire logic [7:0] ad_in,
    output ebi_pkg::ebi_pins_type pins,
    output ebi_pkg::ebi_ctrl_type ctrl_status
);
    typedef enum logic [2:0] {IDLE, ADDR, SETUP, STROBE, TRAIL} ebi_state_type;

    ebi_pkg::ebi_ctrl_type ctrl_r;
    ebi_state_type state_r;
    ebi_pkg::ebi_req_type cur_r;
    logic ext_r;
    logic [1:0] wait_r;
    logic [1:0] cnt_r;
    logic [7:0] ad_out_r;
    logic ad_drive_r;
    logic [7:0] hi_r;
    logic ale_r;
    logic rd_n_r;
    logic wr_n_r;
    logic rd_valid_r;
    logic [2:0] rd_pend_r;
    logic [7:0] rd_data_r;
    logic [7:0] sync1_r, sync2_r, sync3_r;
    logic dec_ext;
    logic [1:0] dec_wait;
    logic [7:0] keep_out;
    logic [7:0] keep_oe_n;
    logic [7:0] hi_own;

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            // R25
            ctrl_r.enable <= ebi_pkg::ENABLE_RST;
            ctrl_r.legacy <= 1'b0;
            ctrl_r.keeper_en <= ebi_pkg::KEEPER_RST;
            ctrl_r.sector_limit <= ebi_pkg::SECTOR_RST;
            ctrl_r.upper_sector_wait <= ebi_pkg::WAIT_NONE;
            ctrl_r.lower_sector_wait <= ebi_pkg::WAIT_NONE;
            ctrl_r.high_addr_release_mask <= ebi_pkg::MASK_RST;
        end
        else if (ctrl_wr)
        begin
            ctrl_r <= ctrl_in; // R21
            if (ctrl_in.legacy)
            begin
                // R22: legacy hides the extended controls
                ctrl_r.keeper_en <= 1'b0;
                ctrl_r.sector_limit <= ebi_pkg::SECTOR_RST;
                ctrl_r.high_addr_release_mask <= ebi_pkg::MASK_RST;
            end
        end
    end
    assign ctrl_status = ctrl_r;

    ebi_addr_decode u_dec
    (
        .addr(req.addr),
        .enable(ctrl_r.enable),
        .legacy(ctrl_r.legacy),
        .sector_limit(ctrl_r.sector_limit),
        .upper_sector_wait(ctrl_r.upper_sector_wait),
        .lower_sector_wait(ctrl_r.lower_sector_wait),
        .is_external(dec_ext),
        .wait_sel(dec_wait)
    );

    // ------------------------------------------------------------
    // access sequencer
    // ------------------------------------------------------------
    // an access is only taken in IDLE; the CPU waits on req_ready
    assign req_ready = (state_r == IDLE);

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state_r <= IDLE;
            cur_r <= '0;
            ext_r <= 1'b0;
            wait_r <= ebi_pkg::WAIT_NONE;
            cnt_r <= 2'h0;
        end
        else
        begin
            unique case (state_r)
                IDLE:
                begin
                    if (req.valid && ctrl_r.enable)
                    begin
                        cur_r <= req;
                        ext_r <= dec_ext; // R03
                        wait_r <= dec_wait; // R12
                        state_r <= ADDR;
                    end
                end
                ADDR:
                    state_r <= SETUP;
                SETUP:
                begin
                    cnt_r <= ebi_pkg::STROBE_BASE;
                    state_r <= STROBE;
                end
                STROBE:
                begin
                    // R24: one extra strobe cycle per wait step
                    if (cnt_r == wait_r)
                        state_r <= cur_r.next_is_ram ? TRAIL : IDLE; // R13
                    else
                        cnt_r <= cnt_r + 2'h1;
                end
                TRAIL:
                    state_r <= IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ale_r <= 1'b0;
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            ad_out_r <= 8'h00;
            ad_drive_r <= 1'b0;
            hi_r <= 8'h00;
        end
        else
        begin
            unique case (state_r)
                IDLE:
                begin
                    rd_n_r <= 1'b1;
                    wr_n_r <= 1'b1;
                    ale_r <= req.valid && ctrl_r.enable; // R20: latch opens
                    ad_out_r <= req.addr[7:0];
                    hi_r <= req.addr[15:8]; // R16: address unchanged
                    ad_drive_r <= req.valid && ctrl_r.enable;
                end
                ADDR:
                    // address still on the bus as the latch strobe falls
                    ale_r <= 1'b0; // R04
                SETUP:
                begin
                    ale_r <= 1'b0; // R05
                    ad_out_r <= cur_r.wdata;
                    ad_drive_r <= cur_r.write;
                    rd_n_r <= !(ext_r && !cur_r.write); // R06 R24
                    wr_n_r <= !(ext_r && cur_r.write); // R06 R24
                end
                STROBE:
                begin
                    ale_r <= 1'b0; // R05
                    if (cnt_r == wait_r)
                    begin
                        rd_n_r <= 1'b1;
                        wr_n_r <= 1'b1;
                        ale_r <= cur_r.next_is_ram; // R13
                    end
                end
                TRAIL:
                begin
                    ale_r <= 1'b0;
                    ad_drive_r <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // read data capture
    // ------------------------------------------------------------
    // the pads are asynchronous to core_clk; three stages, accepted
    // when the last two agree
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            sync1_r <= 8'h00;
            sync2_r <= 8'h00;
            sync3_r <= 8'h00;
        end
        else
        begin
            sync1_r <= ad_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            rd_pend_r <= 3'h0;
            rd_valid_r <= 1'b0;
            rd_data_r <= 8'h00;
        end
        else
        begin
            // the strobe's last cycle still has three stages to cross, so the
            // answer trails it; limitation: the memory must hold its data for
            // one cycle after the read strobe rises
            rd_pend_r <= {rd_pend_r[1:0],
                state_r == STROBE && cnt_r == wait_r && !cur_r.write && ext_r};
            rd_valid_r <= rd_pend_r[2];
            if (rd_pend_r[2])
                rd_data_r <= (sync2_r == sync3_r) ? sync3_r : rd_data_r;
        end
    end
    assign rd_valid = rd_valid_r;
    assign rd_data = rd_data_r;
    assign access_external = ext_r && (state_r != IDLE);

    ebi_bus_keeper u_keep
    (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .keep_en(ctrl_r.keeper_en && ctrl_r.enable),
        // kept off while the memory answers a read and its data crosses the stages
        .released(!ad_drive_r && rd_n_r && (rd_pend_r == 3'h0)),
        .pad_in(ad_drive_r ? ad_out_r : sync3_r), // R11
        .keep_out(keep_out),
        .keep_oe_n(keep_oe_n)
    );

    // ------------------------------------------------------------
    // pin muxing
    // ------------------------------------------------------------
    // R23: mask value n releases the top n high address bits
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_hi
            assign hi_own[gi] = (ctrl_r.high_addr_release_mask == 3'h0)
                || (gi < (8 - ctrl_r.high_addr_release_mask));
        end
    endgenerate

    always_comb
    begin
        pins.ad_pullup = port_ad_val; // R09
        if (ctrl_r.enable)
        begin
            // R01 R02: directions come from the interface, not the port, except for released high address bits
            pins.ad_out = ad_drive_r ? ad_out_r : keep_out;
            pins.ad_oe_n = ad_drive_r ? 8'h00 : keep_oe_n;
            pins.ale = ale_r;
            pins.rd_n = rd_n_r;
            pins.wr_n = wr_n_r;
            pins.strobe_oe_n = 1'b0; // R02
            for (int i = 0; i < 8; i++)
            begin
                pins.hi_out[i] = hi_own[i] ? hi_r[i] : port_hi_val[i]; // R23
                pins.hi_oe_n[i] = hi_own[i] ? 1'b0 : !port_hi_dir[i];
            end
        end
        else
        begin
            // R07
            pins.ad_out = port_ad_val;
            pins.ad_oe_n = ~port_ad_dir;
            pins.hi_out = port_hi_val;
            pins.hi_oe_n = ~port_hi_dir;
            pins.ale = 1'b0;
            pins.rd_n = 1'b1;
            pins.wr_n = 1'b1;
            pins.strobe_oe_n = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_start;
        state_r == IDLE && req.valid && ctrl_r.enable;
    endsequence

    a_ale_open: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_start |=> ale_r ##1 !ale_r) // R04
        else $error("latch strobe not pulsed at access start");
    a_ale_low: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_r == SETUP |=> !ale_r) // R05
        else $error("latch strobe high in data phase");
    a_int_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_r != IDLE && !ext_r |=> rd_n_r && wr_n_r) // R06
        else $error("strobe on internal access");
    a_strobe_excl: assert property (@(posedge core_clk) disable iff (sys_rst)
        !(!rd_n_r && !wr_n_r)) // R24
        else $error("read and write strobes together");
    a_wait_len: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_r == SETUP && wait_r == 2'h3 |=> (state_r == STROBE) [*4]) // R12
        else $error("strobe phase wrong length");
    a_trail_only: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_r == TRAIL |-> cur_r.next_is_ram && $past(ale_r == 1'b0)) // R13
        else $error("trailing latch pulse without next ram access");
    a_low_int: assert property (@(posedge core_clk) disable iff (sys_rst)
        req.addr < ebi_pkg::INT_LIMIT_LEGACY |-> !dec_ext) // R16
        else $error("internal address decoded external");
    a_off_pins: assert property (@(posedge core_clk) disable iff (sys_rst)
        !ctrl_r.enable |-> pins.ad_out == port_ad_val && pins.rd_n) // R07
        else $error("pins not returned to port when disabled");
    a_pullup: assert property (@(posedge core_clk) disable iff (sys_rst)
        pins.ad_pullup == port_ad_val) // R09
        else $error("pull-up mismatch");
endmodule
`default_nettype wire

// File: testbench/ebi_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ebi_mem_model
(
    input wire logic core_clk,
    input wire ebi_pkg::ebi_pins_type pins,
    output logic [7:0] ad_level
);
    logic [7:0] mem [0:32767];
    logic [7:0] lo_latch;
    logic [7:0] last_r;
    logic hold_r;
    logic drive;
    logic [14:0] maddr;
    initial
    begin
        last_r = 8'h00;
        hold_r = 1'b0;
    end
    // ------------------------------------------------------------
    // address latch and memory
    // ------------------------------------------------------------
    always_latch
    begin
        if (pins.ale)
            lo_latch = pins.ad_out;
    end
    // a 32K part: the top address line is left unconnected
    assign maddr = {pins.hi_out[6:0], lo_latch};
    // answers from the strobe level, not a clock phase; one cycle of hold after
    assign drive = !pins.rd_n || hold_r;
    always @(posedge core_clk)
    begin
        hold_r <= !pins.rd_n;
        last_r <= ad_level;
        if (!pins.wr_n)
            mem[maddr] <= ad_level;
    end
    // ------------------------------------------------------------
    // wire level
    // ------------------------------------------------------------
    // a floating line flips each cycle so a stale value never passes
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (!pins.ad_oe_n[i])
                ad_level[i] = pins.ad_out[i];
            else if (drive)
                ad_level[i] = mem[maddr][i];
            else if (pins.ad_pullup[i])
                ad_level[i] = 1'b1;
            else
                ad_level[i] = ~last_r[i];
        end
    end
endmodule
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct {
        logic [15:0] addr;
        logic [7:0] data;
        logic [1:0] uw;
        logic [1:0] lw;
        logic leg;
        logic ext;
        logic [15:0] wt;
    } ebi_row_type;
    logic core_clk, sys_rst, ctrl_wr;
    ebi_pkg::ebi_ctrl_type ctrl_in, ctrl_status, ctrl_exp;
    ebi_pkg::ebi_req_type req;
    ebi_pkg::ebi_pins_type pins;
    logic req_ready, rd_valid, access_external;
    logic [7:0] rd_data, port_ad_val, port_ad_dir, port_hi_val, port_hi_dir, ad_in;
    int n_mismatch, tests_run, cyc;
    logic [15:0] stb, ale_n, vld_at, overlap, oe_seen, rdy_at;
    logic saw_rd, saw_wr, saw_ext;
    logic [7:0] got, lo_seen, hi_seen;
    ebi_row_type rows [9];

    ebi_core dut_u
    (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .ctrl_wr(ctrl_wr),
        .ctrl_in(ctrl_in),
        .req(req),
        .req_ready(req_ready),
        .rd_valid(rd_valid),
        .rd_data(rd_data),
        .access_external(access_external),
        .port_ad_val(port_ad_val),
        .port_ad_dir(port_ad_dir),
        .port_hi_val(port_hi_val),
        .port_hi_dir(port_hi_dir),
        .ad_in(ad_in),
        .pins(pins),
        .ctrl_status(ctrl_status)
    );
    ebi_mem_model mem_u
    (
        .core_clk(core_clk),
        .pins(pins),
        .ad_level(ad_in)
    );

    always #2.5 core_clk = ~core_clk;
    // whole run is a few hundred cycles
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic set_ctrl(input ebi_pkg::ebi_ctrl_type c);
        ctrl_in = c;
        ctrl_wr = 1'b1;
        @(posedge core_clk);
        #1 ctrl_wr = 1'b0;
    endtask

    task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d,
                          input logic nxt);
        req = '{1'b1, wr, a, d, nxt};
        {stb, ale_n, vld_at, overlap, rdy_at} = '0;
        {saw_rd, saw_wr, saw_ext} = 3'b000;
        @(posedge core_clk);
        #1 req.valid = 1'b0;
        for (int n = 1; n < 14; n++)
        begin
            if (n == 1)
                {hi_seen, lo_seen, oe_seen} = {pins.hi_out, pins.ad_out, pins.hi_oe_n, pins.ad_oe_n};
            stb += 16'(!pins.rd_n || !pins.wr_n);
            ale_n += 16'(pins.ale);
            overlap += 16'(pins.ale && (!pins.rd_n || !pins.wr_n));
            saw_rd |= !pins.rd_n;
            saw_wr |= !pins.wr_n;
            saw_ext |= access_external;
            if (rd_valid === 1'b1 && vld_at == 16'h0000)
                {vld_at, got} = {16'(n), rd_data};
            if (req_ready === 1'b1 && n > 1 && rdy_at == 16'h0000)
                rdy_at = 16'(n);
            // a read answers a few cycles after the sequencer is idle again
            if (rdy_at != 16'h0000 && (wr || !saw_rd || vld_at != 16'h0000))
                break;
            @(posedge core_clk);
            #1;
        end
    endtask

    initial
    begin
        {core_clk, sys_rst, ctrl_wr, cyc, n_mismatch, tests_run} = '0;
        sys_rst = 1'b1;
        ctrl_in = '0;
        req = '0;
        {port_ad_val, port_ad_dir, port_hi_val, port_hi_dir} = 32'h9600_5C3F;
        ctrl_exp = '{ebi_pkg::ENABLE_RST, 1'b0, ebi_pkg::KEEPER_RST, ebi_pkg::SECTOR_RST,
                     ebi_pkg::WAIT_NONE, ebi_pkg::WAIT_NONE, ebi_pkg::MASK_RST};
        // sector split at 0x8000: addr[15:13] >= 4 is the upper sector
        rows = '{'{16'h1100, 8'hA5, 2'h3, 2'h0, 1'b0, 1'b1, 16'h0000},
                 '{16'h2001, 8'h5A, 2'h0, 2'h1, 1'b0, 1'b1, 16'h0001},
                 '{16'h7FFF, 8'h3C, 2'h1, 2'h2, 1'b0, 1'b1, 16'h0002},
                 '{16'h8000, 8'hC3, 2'h3, 2'h0, 1'b0, 1'b1, 16'h0003},
                 '{16'h90FF, 8'h0F, 2'h2, 2'h3, 1'b0, 1'b1, 16'h0002},
                 '{16'h10FF, 8'h11, 2'h3, 2'h3, 1'b0, 1'b0, 16'h0000},
                 '{16'h0000, 8'h22, 2'h3, 2'h3, 1'b0, 1'b0, 16'h0000},
                 '{16'h1000, 8'h99, 2'h3, 2'h0, 1'b1, 1'b1, 16'h0001},
                 '{16'h0FFF, 8'h44, 2'h1, 2'h1, 1'b1, 1'b0, 16'h0000}};
        repeat (3) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        check("reset ctrl", 16'(ctrl_status), 16'(ctrl_exp));
        check("idle ad", {pins.ad_out, pins.ad_oe_n}, 16'h96FF);
        check("idle hi", {pins.hi_out, pins.hi_oe_n}, 16'h5CC0);
        check("idle strobes", {pins.ale, pins.rd_n, pins.wr_n}, 16'h0003);
        check("strobe dir", pins.strobe_oe_n, 16'h0001);
        check("pullups", pins.ad_pullup, 16'h0096);
        // pull-ups off, as software does before sleep
        port_ad_val = 8'h00;
        port_hi_dir = 8'h00;
        foreach (rows[i])
        begin
            set_ctrl('{1'b1, rows[i].leg, 1'b0, 3'h4, rows[i].uw, rows[i].lw, 3'h0});
            access(1'b1, rows[i].addr, rows[i].data, 1'b1);
            check("wr flags", {saw_ext, saw_rd, saw_wr}, {rows[i].ext, 1'b0, rows[i].ext});
            check("wr strobe", stb, rows[i].ext ? rows[i].wt + 16'h0001 : 16'h0000);
            check("wr ale", ale_n, 16'h0002);
            check("ale low", overlap, 16'h0000);
            check("addr out", {hi_seen, lo_seen}, rows[i].addr);
            check("override", oe_seen, 16'h0000);
            access(1'b0, rows[i].addr, 8'h00, 1'b0);
            check("rd flags", {saw_ext, saw_rd, saw_wr}, {rows[i].ext, rows[i].ext, 1'b0});
            check("rd strobe", stb, rows[i].ext ? rows[i].wt + 16'h0001 : 16'h0000);
            check("rd ale", ale_n, 16'h0001);
            if (rows[i].ext)
            begin
                check("rd ready", rdy_at, rows[i].wt + 16'h0004);
                check("rd latency", vld_at, rows[i].wt + 16'h0007);
                check("rd data", got, rows[i].data);
            end
        end
        set_ctrl('0);
        access(1'b0, 16'h8000, 8'h00, 1'b1);
        check("off activity", {saw_ext, saw_rd, saw_wr}, 16'h0000);
        check("off counts", stb | ale_n | vld_at, 16'h0000);
        port_hi_val = 8'hA0;
        set_ctrl('{1'b1, 1'b0, 1'b0, 3'h0, 2'h0, 2'h0, 3'h3});
        access(1'b1, 16'h9234, 8'h77, 1'b0);
        check("released hi", hi_seen, 16'h00B2);
        check("strobe dir on", pins.strobe_oe_n, 16'h0000);
        set_ctrl('{1'b1, 1'b0, 1'b1, 3'h0, 2'h3, 2'h3, 3'h0});
        access(1'b1, 16'h4000, 8'h6B, 1'b0);
        access(1'b0, 16'h4000, 8'h00, 1'b0);
        repeat (6) @(posedge core_clk);
        #1 check("kept level", ad_in, 16'h006B);
        repeat (3) @(posedge core_clk);
        #1 check("kept still", ad_in, 16'h006B);
        sys_rst = 1'b1;
        @(posedge core_clk);
        #1 sys_rst = 1'b0;
        check("rerun reset", 16'(ctrl_status), 16'(ctrl_exp));
        check("rerun ad", {pins.ad_out, pins.ad_oe_n}, 16'h00FF);
        end_of_test();
    end
endmodule
`default_nettype wire
